// *** logic/spwm_pkg.sv ***
// constants, register map and field layout of the six channel pwm unit
// Overview of operation
// - six independent channels, each with own counter, start, toggle and output
// - per channel 16-bit start value, read/write, where counting begins
// - per channel 16-bit toggle value, read/write, where output changes level
// - per channel live 16-bit count readable by software at any time
// - one 18-bit read/write configuration register shared by all channels
// - shared configuration selects each channel's counting clock separately
// - shared configuration inverts each channel output individually
`default_nettype none

package spwm_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int SPWM_NCH  = 6;
  localparam int SPWM_CW   = 16;
  localparam int SPWM_CFGW = 18;
  localparam int SPWM_AW   = 8;
  localparam int SPWM_DW   = 32;

  // ---------------------------------------------------------------
  // register map: channel n at n*10h, shared config after them
  // ---------------------------------------------------------------
  localparam int             SPWM_CH_LSB    = 4;
  localparam logic [3:0]     SPWM_OFS_START = 4'h0;
  localparam logic [3:0]     SPWM_OFS_TOGGLE = 4'h4;
  localparam logic [3:0]     SPWM_OFS_COUNT = 4'h8;
  localparam logic [7:0]     SPWM_CFG_ADDR  = 8'h60;

  // ---------------------------------------------------------------
  // config fields, three bits per channel
  // ---------------------------------------------------------------
  localparam int SPWM_F_W   = 3;
  localparam int SPWM_F_EN  = 0;
  localparam int SPWM_F_CLK = 1;
  localparam int SPWM_F_INV = 2;

  // ---------------------------------------------------------------
  // reset values and counter limits
  // ---------------------------------------------------------------
  localparam logic [15:0] SPWM_RST_START  = 16'h0000;
  localparam logic [15:0] SPWM_RST_TOGGLE = 16'h8000;
  localparam logic [17:0] SPWM_RST_CFG    = 18'h00000;
  localparam logic [15:0] SPWM_CNT_TOP    = 16'hffff;

  // ---------------------------------------------------------------
  // timing: slow counting clock as an enable from mclk
  // ---------------------------------------------------------------
  localparam int SPWM_MCLK_KHZ = 250000;
  localparam int SPWM_SLOW_KHZ = 1000;
  localparam int SPWM_SLOW_DIV = SPWM_MCLK_KHZ / SPWM_SLOW_KHZ;

  // ---------------------------------------------------------------
  // bus responses
  // ---------------------------------------------------------------
  localparam logic [1:0] SPWM_RESP_OKAY   = 2'b00;
  localparam logic [1:0] SPWM_RESP_SLVERR = 2'b10;

endpackage

`default_nettype wire

// *** logic/spwm_channel.sv ***
// one pwm channel: counter with reload and compare output
`timescale 1ns/100ps
`default_nettype none

module spwm_channel
  import spwm_pkg::*;
(
  input  wire logic               mclk,          // system clock
  input  wire logic               resetn,        // async reset, active low
  input  wire logic               enable,        // channel runs
  input  wire logic               tick,          // count enable this cycle
  input  wire logic               invert,        // output phase flip
  input  wire logic [SPWM_CW-1:0] start_value,   // reload value
  input  wire logic [SPWM_CW-1:0] toggle_point,  // output edge position
  output var  logic [SPWM_CW-1:0] count,         // live count
  output var  logic               pwm_out        // channel output
);

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count <= SPWM_RST_START;
    end else if (!enable) begin
      count <= start_value;
    end else if (tick) begin
      if (count == SPWM_CNT_TOP) begin
        count <= start_value;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // output compare
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= (count >= toggle_point) ^ invert;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_cnt_wrap: assert property (
    @(posedge mclk) disable iff (!resetn)
    enable && tick && count == SPWM_CNT_TOP |=> count == $past(start_value))
    else $error("counter did not reload start after ffff");

  a_cnt_step: assert property (
    @(posedge mclk) disable iff (!resetn)
    enable && tick && count != SPWM_CNT_TOP |=> count == $past(count) + 16'h0001)
    else $error("counter did not step by one");

  a_cnt_hold: assert property (
    @(posedge mclk) disable iff (!resetn)
    enable && !tick |=> count == $past(count))
    else $error("counter moved without its clock enable");

  a_idle_load: assert property (
    @(posedge mclk) disable iff (!resetn)
    !enable |=> count == $past(start_value))
    else $error("idle counter not at start value");

  a_out_level: assert property (
    @(posedge mclk) disable iff (!resetn)
    $stable(count) && $stable(toggle_point) && $changed(invert) |=> $changed(pwm_out))
    else $error("phase flip did not flip the output");

endmodule // spwm_channel

`default_nettype wire

// *** logic/spwm_unit.sv ***
// six channel pwm unit with axi4-lite register slave
`timescale 1ns/100ps
`default_nettype none

module spwm_unit
  import spwm_pkg::*;
#(
  parameter int SLOW_DIV = SPWM_SLOW_DIV          // mclk cycles per slow tick
) (
  input  wire logic                mclk,          // system clock, 250 MHz
  input  wire logic                resetn,        // async reset, active low
  input  wire logic [SPWM_AW-1:0]  awaddr,        // write address
  input  wire logic                awvalid,       // write address valid
  output var  logic                awready,       // write address ready
  input  wire logic [SPWM_DW-1:0]  wdata,         // write data
  input  wire logic [3:0]          wstrb,         // write byte enables
  input  wire logic                wvalid,        // write data valid
  output var  logic                wready,        // write data ready
  output var  logic [1:0]          bresp,         // write response
  output var  logic                bvalid,        // write response valid
  input  wire logic                bready,        // write response ready
  input  wire logic [SPWM_AW-1:0]  araddr,        // read address
  input  wire logic                arvalid,       // read address valid
  output var  logic                arready,       // read address ready
  output var  logic [SPWM_DW-1:0]  rdata,         // read data
  output var  logic [1:0]          rresp,         // read response
  output var  logic                rvalid,        // read data valid
  input  wire logic                rready,        // read data ready
  output var  logic [SPWM_NCH-1:0] pwm_out        // channel outputs
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  // slow tick must be a true pulse with idle cycles between
  if (SLOW_DIV < 3) begin : g_bad_div
    $error("SLOW_DIV must be at least 3");
  end

  localparam int DIVW = $clog2(SLOW_DIV);
  localparam logic [DIVW-1:0] DIV_LAST = DIVW'(SLOW_DIV - 1);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [SPWM_CW-1:0]   start_val [SPWM_NCH];
  logic [SPWM_CW-1:0]   toggle_pt [SPWM_NCH];
  logic [SPWM_CW-1:0]   count     [SPWM_NCH];
  logic [SPWM_CFGW-1:0] cfg;
  logic [DIVW-1:0]      div_cnt;
  logic                 slow_tick;
  logic                 aw_held;
  logic                 w_held;
  logic [SPWM_AW-1:0]   aw_addr;
  logic [SPWM_DW-1:0]   w_data;
  logic [3:0]           w_strb;
  logic                 do_write;
  logic                 wr_ok;
  logic                 aw_rok;
  logic                 ar_ok;
  logic [SPWM_DW-1:0]   aw_old;
  logic [SPWM_DW-1:0]   ar_word;
  logic [SPWM_DW-1:0]   next_word;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] ch_of(input logic [SPWM_AW-1:0] a);
    return a[SPWM_CH_LSB +: 3];
  endfunction

  function automatic logic [3:0] kind_of(input logic [SPWM_AW-1:0] a);
    return a[SPWM_CH_LSB-1:0];
  endfunction

  function automatic logic [SPWM_DW-1:0] merge(input logic [SPWM_DW-1:0] old,
                                               input logic [SPWM_DW-1:0] d,
                                               input logic [3:0]         s);
    logic [SPWM_DW-1:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // decode and fetch one register: {hit, word}
  function automatic logic [SPWM_DW:0] read_word(input logic [SPWM_AW-1:0] a);
    logic [2:0]         ch;
    logic [SPWM_DW-1:0] w;
    logic               hit;
    ch  = ch_of(a);
    w   = '0;
    hit = 1'b0;
    if (a == SPWM_CFG_ADDR) begin
      w   = SPWM_DW'(cfg);
      hit = 1'b1;
    end else if (a[SPWM_AW-1:SPWM_CH_LSB] < 4'(SPWM_NCH)) begin
      // all address bits above the kind take part, so 80h and up never alias a channel
      case (kind_of(a))
        SPWM_OFS_START: begin
          w   = SPWM_DW'(start_val[ch]);
          hit = 1'b1;
        end
        SPWM_OFS_TOGGLE: begin
          w   = SPWM_DW'(toggle_pt[ch]);
          hit = 1'b1;
        end
        SPWM_OFS_COUNT: begin
          w   = SPWM_DW'(count[ch]);
          hit = 1'b1;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end
    return {hit, w};
  endfunction

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  always_comb begin
    {ar_ok, ar_word} = read_word(araddr);
    {aw_rok, aw_old} = read_word(aw_addr);
    // count readback is read only, so a write to it is refused
    wr_ok     = aw_rok && (aw_addr == SPWM_CFG_ADDR || kind_of(aw_addr) != SPWM_OFS_COUNT);
    next_word = merge(aw_old, w_data, w_strb);
    do_write  = aw_held && w_held && !bvalid;
  end

  // ---------------------------------------------------------------
  // write address and data channels
  // ---------------------------------------------------------------
  // either may arrive first; each is parked until the response is taken
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      awready <= 1'b1;
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_held <= 1'b1;
      aw_addr <= awaddr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wready <= 1'b1;
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_held <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bvalid <= 1'b0;
      bresp  <= SPWM_RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= wr_ok ? SPWM_RESP_OKAY : SPWM_RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= SPWM_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= ar_word;
      rresp   <= ar_ok ? SPWM_RESP_OKAY : SPWM_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < SPWM_NCH; i++) begin
        start_val[i] <= SPWM_RST_START;
        toggle_pt[i] <= SPWM_RST_TOGGLE;
      end
    end else if (do_write && wr_ok && aw_addr != SPWM_CFG_ADDR) begin
      for (int i = 0; i < SPWM_NCH; i++) begin
        if (ch_of(aw_addr) == 3'(i)) begin
          if (kind_of(aw_addr) == SPWM_OFS_START) begin
            start_val[i] <= next_word[SPWM_CW-1:0];
          end
          if (kind_of(aw_addr) == SPWM_OFS_TOGGLE) begin
            toggle_pt[i] <= next_word[SPWM_CW-1:0];
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg <= SPWM_RST_CFG;
    end else if (do_write && aw_addr == SPWM_CFG_ADDR) begin
      cfg <= next_word[SPWM_CFGW-1:0];
    end
  end

  // ---------------------------------------------------------------
  // slow counting clock
  // ---------------------------------------------------------------
  // one enable pulse every SLOW_DIV cycles keeps the design on one clock
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_cnt   <= '0;
      slow_tick <= 1'b0;
    end else begin
      slow_tick <= (div_cnt == DIV_LAST);
      div_cnt   <= (div_cnt == DIV_LAST) ? '0 : div_cnt + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // channels
  // ---------------------------------------------------------------
  // six channels
  for (genvar g = 0; g < SPWM_NCH; g++) begin : g_ch
    spwm_channel u_ch (
      .mclk         (mclk),
      .resetn       (resetn),
      .enable       (cfg[g*SPWM_F_W + SPWM_F_EN]),
      .tick         (cfg[g*SPWM_F_W + SPWM_F_CLK] ? slow_tick : 1'b1),
      .invert       (cfg[g*SPWM_F_W + SPWM_F_INV]),
      .start_value  (start_val[g]),
      .toggle_point (toggle_pt[g]),
      .count        (count[g]),
      .pwm_out      (pwm_out[g])
    );
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_cfg_write: assert property (
    @(posedge mclk) disable iff (!resetn)
    do_write && aw_addr == SPWM_CFG_ADDR && w_strb == 4'hf
      |=> cfg == $past(w_data[SPWM_CFGW-1:0]))
    else $error("config write not stored");

  a_start_write: assert property (
    @(posedge mclk) disable iff (!resetn)
    do_write && aw_addr == {4'h0, SPWM_OFS_START} && w_strb == 4'hf
      |=> start_val[0] == $past(w_data[SPWM_CW-1:0]))
    else $error("start value write not stored");

  a_toggle_write: assert property (
    @(posedge mclk) disable iff (!resetn)
    do_write && aw_addr == {4'h0, SPWM_OFS_TOGGLE} && w_strb == 4'hf
      |=> toggle_pt[0] == $past(w_data[SPWM_CW-1:0]))
    else $error("toggle value write not stored");

  a_count_read: assert property (
    @(posedge mclk) disable iff (!resetn)
    arvalid && arready && araddr == {4'h0, SPWM_OFS_COUNT}
      |=> rvalid && rresp == SPWM_RESP_OKAY && rdata == SPWM_DW'($past(count[0])))
    else $error("count readback wrong");

  a_slow_tick: assert property (
    @(posedge mclk) disable iff (!resetn)
    slow_tick |=> !slow_tick [*2])
    else $error("slow tick not a lone pulse");

  a_resp_hold: assert property (
    @(posedge mclk) disable iff (!resetn)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");

endmodule // spwm_unit

`default_nettype wire

// *** bench/tb_six_channel_pwm_unit.sv ***
// self-checking register and output bench for the six channel pwm unit
`timescale 1ns/100ps
`default_nettype none

module tb_six_channel_pwm_unit
  import spwm_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int DIV                  = 4;
  localparam int EXP_HI[SPWM_NCH]     = '{16, 48, 16, 0, 0, 64};
  localparam int EXP_RISE[SPWM_NCH]   = '{16, 16, 4, 0, 0, 0};

  logic                mclk;
  logic                resetn;
  logic [SPWM_AW-1:0]  awaddr;
  logic                awvalid;
  logic                awready;
  logic [SPWM_DW-1:0]  wdata;
  logic [3:0]          wstrb;
  logic                wvalid;
  logic                wready;
  logic [1:0]          bresp;
  logic                bvalid;
  logic                bready;
  logic [SPWM_AW-1:0]  araddr;
  logic                arvalid;
  logic                arready;
  logic [SPWM_DW-1:0]  rdata;
  logic [1:0]          rresp;
  logic                rvalid;
  logic                rready;
  logic [SPWM_NCH-1:0] pwm_out;
  int                  err_total;
  int                  compares;
  int                  hi[SPWM_NCH];
  int                  rise[SPWM_NCH];

  // small divider keeps the slow channel period short
  spwm_unit #(.SLOW_DIV(DIV)) spwm_unit_inst (
    .mclk(mclk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pwm_out(pwm_out)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic hang(input string nm);
    err_total++;
    $display("unexpected %s: expected handshake seen none", nm);
    end_of_test();
  endtask

  function automatic logic [7:0] ad(input int n, input logic [3:0] o);
    return 8'(n << SPWM_CH_LSB) | {4'h0, o};
  endfunction

  // address and data offered together, each released once taken
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    int   n;
    logic aw_ok;
    logic w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge mclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      n++;
      if (n > 100) hang("write request");
    end
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (n > 100) hang("write response");
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("bresp", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic bus_read(input logic [7:0] a, input string nm, input logic [31:0] exp,
                          input logic [1:0] er);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (n > 100) hang("read request");
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    // raised only once the address is taken, so back-to-back reads never set it twice in one step
    rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (n > 100) hang("read response");
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    check(nm, rdata, exp);
    check("rresp", {30'h0, rresp}, {30'h0, er});
  endtask

  // whole periods only, so the result does not depend on phase
  task automatic measure();
    logic [SPWM_NCH-1:0] prev;
    repeat (8) @(posedge mclk);
    prev = pwm_out;
    for (int i = 0; i < SPWM_NCH; i++) begin
      hi[i] = 0;
      rise[i] = 0;
    end
    repeat (64) begin
      @(posedge mclk);
      for (int i = 0; i < SPWM_NCH; i++) begin
        if (pwm_out[i] === 1'b1) hi[i]++;
        if (pwm_out[i] === 1'b1 && prev[i] === 1'b0) rise[i]++;
      end
      prev = pwm_out;
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    err_total = 0;
    compares = 0;
    resetn = 1'b0;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);

    for (int n = 0; n < SPWM_NCH; n++) begin
      bus_read(ad(n, SPWM_OFS_START), "start", 32'h0, SPWM_RESP_OKAY);
      bus_read(ad(n, SPWM_OFS_TOGGLE), "toggle", {16'h0, SPWM_RST_TOGGLE}, SPWM_RESP_OKAY);
      bus_read(ad(n, SPWM_OFS_COUNT), "count", 32'h0, SPWM_RESP_OKAY);
    end
    bus_read(SPWM_CFG_ADDR, "config", {14'h0, SPWM_RST_CFG}, SPWM_RESP_OKAY);
    $display("test reset values done");

    // upper halves written as dead and beef must read back as zero
    for (int n = 0; n < SPWM_NCH; n++) begin
      bus_write(ad(n, SPWM_OFS_START), 32'hdead_0000 | 32'(n * 16'h1111), 4'hf, SPWM_RESP_OKAY);
      bus_write(ad(n, SPWM_OFS_TOGGLE), 32'hbeef_f000 - 32'(n), 4'hf, SPWM_RESP_OKAY);
    end
    for (int n = 0; n < SPWM_NCH; n++) begin
      bus_read(ad(n, SPWM_OFS_START), "start", 32'(n * 16'h1111), SPWM_RESP_OKAY);
      bus_read(ad(n, SPWM_OFS_TOGGLE), "toggle", 32'h0000_f000 - 32'(n), SPWM_RESP_OKAY);
      bus_read(ad(n, SPWM_OFS_COUNT), "count", 32'(n * 16'h1111), SPWM_RESP_OKAY);
    end
    $display("test register readback done");

    for (int n = 0; n < SPWM_NCH; n++) begin
      bus_write(ad(n, SPWM_OFS_START), (n < 3) ? 32'hfffc : 32'h0, 4'hf, SPWM_RESP_OKAY);
      bus_write(ad(n, SPWM_OFS_TOGGLE), (n < 3) ? 32'hffff : 32'h8000, 4'hf, SPWM_RESP_OKAY);
    end
    bus_write(ad(4, SPWM_OFS_TOGGLE), 32'h1234_5634, 4'h1, SPWM_RESP_OKAY);
    bus_read(ad(4, SPWM_OFS_TOGGLE), "toggle partial", 32'h8034, SPWM_RESP_OKAY);
    bus_write(ad(2, SPWM_OFS_COUNT), 32'h1234, 4'hf, SPWM_RESP_SLVERR);
    bus_read(ad(2, SPWM_OFS_COUNT), "count kept", 32'hfffc, SPWM_RESP_OKAY);
    bus_write(8'h70, 32'h5555, 4'hf, SPWM_RESP_SLVERR);
    bus_read(8'h70, "unmapped", 32'h0, SPWM_RESP_SLVERR);
    // top address bit set must not alias channel 0
    bus_write(8'h80, 32'h4321, 4'hf, SPWM_RESP_SLVERR);
    bus_read(8'h80, "aliased", 32'h0, SPWM_RESP_SLVERR);
    bus_write(8'h01, 32'h1111, 4'hf, SPWM_RESP_SLVERR);
    bus_read(8'h02, "unaligned", 32'h0, SPWM_RESP_SLVERR);
    bus_read(ad(0, SPWM_OFS_START), "start kept", 32'hfffc, SPWM_RESP_OKAY);
    $display("test refused accesses done");

    // ch0 fast, ch1 fast inverted, ch2 slow, ch5 disabled but inverted
    bus_write(SPWM_CFG_ADDR, 32'hfffe_00e9, 4'hf, SPWM_RESP_OKAY);
    bus_read(SPWM_CFG_ADDR, "config", 32'h0002_00e9, SPWM_RESP_OKAY);
    measure();
    for (int i = 0; i < SPWM_NCH; i++) begin
      check("pwm high cycles", 32'(hi[i]), 32'(EXP_HI[i]));
      check("pwm rising edges", 32'(rise[i]), 32'(EXP_RISE[i]));
    end
    $display("test channel outputs done");
    end_of_test();
  end

endmodule // tb_six_channel_pwm_unit

`default_nettype wire
